// *** pkg/imu_frame_pkg.sv ***
package imu_frame_pkg;

  // Clock and timing
  localparam int unsigned CLK_KHZ          = 200000;
  localparam int unsigned TICK_RATE_HZ     = 200;
  localparam int unsigned TICK_CYCLES      = CLK_KHZ * 1000 / TICK_RATE_HZ;
  localparam int unsigned TX_DELAY_US      = 1000;
  localparam int unsigned TX_DELAY_CYCLES  = TX_DELAY_US * CLK_KHZ / 1000;
  localparam int unsigned TX_LIMIT_US      = 2000;
  localparam int unsigned TX_LIMIT_CYCLES  = TX_LIMIT_US * CLK_KHZ / 1000;
  localparam int unsigned BAUD_KHZ         = 1000;
  localparam int unsigned HALF_BIT_CYCLES  = CLK_KHZ / (2 * BAUD_KHZ);
  localparam int unsigned TICK_W           = 20;
  localparam int unsigned WAIT_W           = 18;
  localparam int unsigned DIV_W            = 7;
  localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(HALF_BIT_CYCLES - 1);

  // Frame layout
  localparam logic [7:0]  FLAG_PATTERN     = 8'h7e;
  localparam logic [7:0]  HEADER_BYTE      = 8'h7e;
  localparam logic [4:0]  PAYLOAD_BYTES    = 5'h10;
  localparam logic [4:0]  BODY_BYTES       = 5'h12;
  localparam logic [4:0]  CHECKSUM_IDX     = 5'h0f;
  localparam logic [4:0]  FIRST_COUNT_IDX  = 5'h03;
  localparam logic [2:0]  MAX_ONES         = 3'h5;
  localparam logic [15:0] CRC_INIT         = 16'hffff;
  localparam logic [15:0] CRC_POLY         = 16'h8408;

  // Status byte bit positions (shown active low) and pin vector order
  localparam int unsigned ST_SELFTEST_BIT  = 7;
  localparam int unsigned ST_GYRO_EN_BIT   = 6;
  localparam int unsigned ST_NOT_HOT_BIT   = 5;
  localparam int unsigned ST_NOT_COLD_BIT  = 4;
  localparam int unsigned PIN_INIT         = 0;
  localparam int unsigned PIN_SELFTEST     = 1;
  localparam int unsigned PIN_GYRO_EN      = 2;
  localparam int unsigned PIN_NOT_HOT      = 3;
  localparam int unsigned PIN_NOT_COLD     = 4;
  localparam int unsigned PIN_COUNT        = 5;

  // Three 16-bit increments, x/y/z or roll/pitch/yaw
  typedef struct packed {
    logic [2:0][15:0] cnt;
  } triad_t;

  // Unit health pins, active high
  typedef struct packed {
    logic not_cold;
    logic not_hot;
    logic gyro_en;
    logic selftest_ok;
    logic init_done;
  } health_t;

  typedef enum logic [1:0] {SER_IDLE, SER_OPEN, SER_BODY, SER_CLOSE} ser_state_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] pin;
    logic [TICK_W-1:0]    tick_cnt;
    logic [WAIT_W-1:0]    wait_cnt;
    logic                 waiting;
    logic                 strobe;
    triad_t               acc_g;
    triad_t               acc_a;
    triad_t               snap_g;
    triad_t               snap_a;
    logic [7:0]           snap_status;
    logic [7:0]           pkt_cnt;
    logic                 prod_active;
    logic [4:0]           prod_idx;
    logic [15:0]          crc;
    logic [7:0]           xsum;
    logic [1:0][7:0]      fifo_mem;
    logic                 wr_ptr;
    logic                 rd_ptr;
    logic [1:0]           fill;
    ser_state_t           ser;
    logic [DIV_W-1:0]     div;
    logic                 sclk;
    logic                 sdata;
    logic [7:0]           shreg;
    logic [2:0]           bit_idx;
    logic [2:0]           ones;
    logic [4:0]           byte_cnt;
    logic                 have_byte;
  } framer_state_t;

endpackage

// *** src/imu_sample_frame_transmitter.sv ***
`timescale 1ns/10ps
// Functional notes
// - Validity strobe rises once every 5 ms, 200 Hz.
// - Strobe rises in the same cycle the gyro and accel counts are latched.
// - Strobe falls when the closing flag's last bit has been sent.
// - One packet per strobe period after gyro init; nothing before.
// - Frame completes between 1 ms and 2 ms after strobe rise.
// - Link is transmit only; no receive pins exist.
// - Bit rate 1000 kbaud, within 750 to 1000, synchronous bit-oriented framing.
// - Every byte goes out least significant bit first.
// - Broadcast frame: no address or control byte after the opening flag.
// - Unit generates and drives the serial clock.
// - Serial data changes only on falling serial clock edges, except its return to idle high at frame end, with the clock held high.
// - Frame is flag, 16 data bytes, 2 check bytes, closing flag.
// - Zero inserted after five ones in data and check bytes only.
// - Payload: header 7e, counter, status, six counts high then low, checksum.
// - Count order: gyro x, y, z, then accel roll, pitch, yaw.
// - Last payload byte is XOR of payload bytes one to fifteen.
// - Status bits 7..4: self-test, gyro enabled, not hot, not cold, active low.
// - Gyro count lsb is 0.4 arcsec; 16 bits cover 200 deg/s.
// - Accel count lsb is 3.38e-5 m/s; 16 bits cover 6 g.
// - Accel fields carry velocity counts accumulated over the cycle.
// - Gyro fields carry angle counts accumulated over the cycle.
module imu_sample_frame_transmitter #(
  parameter int unsigned TICK_CYCLES     = imu_frame_pkg::TICK_CYCLES,
  parameter int unsigned TX_DELAY_CYCLES = imu_frame_pkg::TX_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // Health pins from outside the clock domain
  input  wire imu_frame_pkg::health_t health,
  // Sensor increments from logic on mclk
  input  wire logic                  gyro_valid,
  input  wire imu_frame_pkg::triad_t gyro_delta,
  input  wire logic                  accel_valid,
  input  wire imu_frame_pkg::triad_t accel_delta,
  // Serial link and strobe outputs
  output logic                       validity_strobe,
  output logic                       serial_clk,
  output logic                       serial_data
);
  import imu_frame_pkg::*;

  framer_state_t st;
  framer_state_t next_st;
  logic          fall_now;
  logic          fifo_push;
  logic          fifo_pop;
  logic [7:0]    prod_byte;
  logic [15:0]   fcs;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One byte through the reflected CRC, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ b[i];
      r  = {1'b0, r[15:1]};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // Payload byte at an index of the 16-byte message
  function automatic logic [7:0] payload_at(input framer_state_t s, input logic [4:0] idx);
    logic [4:0]  k;
    logic [15:0] w;
    k = idx - FIRST_COUNT_IDX;
    w = (k[4:1] < 4'h3) ? s.snap_g.cnt[k[2:1]] : s.snap_a.cnt[k[2:1] - 2'h3];
    if (idx == 5'h00) begin
      return HEADER_BYTE;
    end else if (idx == 5'h01) begin
      return s.pkt_cnt;
    end else if (idx == 5'h02) begin
      return s.snap_status;
    end else if (idx == CHECKSUM_IDX) begin
      return s.xsum;
    end else begin
      return k[0] ? w[7:0] : w[15:8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational byte source and buffer handshakes

  always_comb begin
    fcs       = ~st.crc;
    if (st.prod_idx < PAYLOAD_BYTES) begin
      prod_byte = payload_at(st, st.prod_idx);
    end else if (st.prod_idx == PAYLOAD_BYTES) begin
      prod_byte = fcs[7:0];
    end else begin
      prod_byte = fcs[15:8];
    end
    fall_now  = st.sclk && (st.div == DIV_LAST);
    fifo_push = st.prod_active && (st.fill != 2'h2);
    fifo_pop  = (st.ser == SER_BODY) && !st.have_byte && (st.fill != 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Three-stage pin capture, level accepted once stages two and three agree
    next_st.sync1 = health;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.pin[i] = st.sync3[i];
      end
    end

    // Accumulate increments over the measurement cycle
    for (int a = 0; a < 3; a++) begin
      if (gyro_valid) begin
        next_st.acc_g.cnt[a] = st.acc_g.cnt[a] + gyro_delta.cnt[a];
      end
      if (accel_valid) begin
        next_st.acc_a.cnt[a] = st.acc_a.cnt[a] + accel_delta.cnt[a];
      end
    end

    // Period counter and strobe rise with the latch
    next_st.tick_cnt = st.tick_cnt + 1'b1;
    if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      if (st.pin[PIN_INIT] && !st.strobe && (st.ser == SER_IDLE)) begin
        next_st.strobe   = 1'b1;
        next_st.waiting  = 1'b1;
        next_st.wait_cnt = '0;
        next_st.snap_g   = st.acc_g;
        next_st.snap_a   = st.acc_a;
        next_st.acc_g    = gyro_valid ? gyro_delta : '0;
        next_st.acc_a    = accel_valid ? accel_delta : '0;
        next_st.snap_status = 8'h00;
        next_st.snap_status[ST_SELFTEST_BIT] = ~st.pin[PIN_SELFTEST];
        next_st.snap_status[ST_GYRO_EN_BIT]  = ~st.pin[PIN_GYRO_EN];
        next_st.snap_status[ST_NOT_HOT_BIT]  = ~st.pin[PIN_NOT_HOT];
        next_st.snap_status[ST_NOT_COLD_BIT] = ~st.pin[PIN_NOT_COLD];
      end
    end

    // Hold off so the frame ends inside its window
    if (st.waiting) begin
      next_st.wait_cnt = st.wait_cnt + 1'b1;
      if (st.wait_cnt == WAIT_W'(TX_DELAY_CYCLES - 1)) begin
        next_st.waiting     = 1'b0;
        next_st.prod_active = 1'b1;
        next_st.prod_idx    = '0;
        next_st.crc         = CRC_INIT;
        next_st.xsum        = 8'h00;
        next_st.ser         = SER_OPEN;
        next_st.bit_idx     = '0;
        next_st.div         = '0;
      end
    end

    // Byte producer: header first, no address or control byte
    if (fifo_push) begin
      next_st.fifo_mem[st.wr_ptr] = prod_byte;
      next_st.wr_ptr   = ~st.wr_ptr;
      next_st.prod_idx = st.prod_idx + 1'b1;
      if (st.prod_idx < PAYLOAD_BYTES) begin
        next_st.crc = crc_step(st.crc, prod_byte);
      end
      if (st.prod_idx < CHECKSUM_IDX) begin
        next_st.xsum = st.xsum ^ prod_byte;
      end
      if (st.prod_idx == BODY_BYTES - 5'h01) begin
        next_st.prod_active = 1'b0;
      end
    end
    if (fifo_pop) begin
      next_st.rd_ptr    = ~st.rd_ptr;
      next_st.shreg     = st.fifo_mem[st.rd_ptr];
      next_st.have_byte = 1'b1;
      next_st.bit_idx   = '0;
    end
    next_st.fill = st.fill + {1'b0, fifo_push} - {1'b0, fifo_pop};

    // Serial clock divider, driven by the unit
    if (st.ser != SER_IDLE) begin
      next_st.div = st.div + 1'b1;
      if (st.div == DIV_LAST) begin
        next_st.div  = '0;
        next_st.sclk = ~st.sclk;
      end
    end

    // Data moves on falling edges only, except the return to idle high at frame end; far end samples on rising
    if (fall_now) begin
      case (st.ser)
        SER_OPEN: begin
          next_st.sdata   = FLAG_PATTERN[st.bit_idx];
          next_st.bit_idx = st.bit_idx + 1'b1;
          if (st.bit_idx == 3'h7) begin
            next_st.ser       = SER_BODY;
            next_st.ones      = '0;
            next_st.byte_cnt  = '0;
            next_st.have_byte = 1'b0;
          end
        end
        SER_BODY: begin
          if (st.ones == MAX_ONES) begin
            next_st.sdata = 1'b0;
            next_st.ones  = '0;
          end else if (st.have_byte) begin
            next_st.sdata   = st.shreg[st.bit_idx];
            next_st.ones    = st.shreg[st.bit_idx] ? st.ones + 1'b1 : '0;
            next_st.bit_idx = st.bit_idx + 1'b1;
            if (st.bit_idx == 3'h7) begin
              next_st.have_byte = 1'b0;
              next_st.byte_cnt  = st.byte_cnt + 1'b1;
            end
          end else if (st.byte_cnt == BODY_BYTES) begin
            next_st.sdata   = FLAG_PATTERN[0];
            next_st.bit_idx = 3'h1;
            next_st.ser     = SER_CLOSE;
          end
        end
        SER_CLOSE: begin
          if (st.bit_idx == 3'h0) begin
            next_st.ser     = SER_IDLE;
            next_st.strobe  = 1'b0;
            next_st.sdata   = 1'b1;
            next_st.sclk    = 1'b1;
            next_st.div     = '0;
            next_st.pkt_cnt = st.pkt_cnt + 1'b1;
          end else begin
            next_st.sdata   = FLAG_PATTERN[st.bit_idx];
            next_st.bit_idx = st.bit_idx + 1'b1;
          end
        end
        default: begin
          next_st.sdata = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= '0;
      st.ser   <= SER_IDLE;
      st.sclk  <= 1'b1;
      st.sdata <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops; no receive path exists
  assign validity_strobe = st.strobe;
  assign serial_clk      = st.sclk;
  assign serial_data     = st.sdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  int unsigned since_rise;
  logic        seen_rise;

  // Cycles since the last strobe rise, cleared on the rise edge itself
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      since_rise <= 0;
      seen_rise  <= 1'b0;
    end else begin
      since_rise <= (next_st.strobe && !st.strobe) ? 0 : since_rise + 1;
      if (next_st.strobe && !st.strobe) begin
        seen_rise <= 1'b1;
      end
    end
  end

  sequence fall_edge;
    fall_now;
  endsequence

  sequence stuff_due;
    (st.ser == SER_BODY) && (st.ones == MAX_ONES);
  endsequence

  sequence body_bit_due;
    (st.ser == SER_BODY) && st.have_byte && (st.ones != MAX_ONES);
  endsequence

  sequence close_bit_due;
    (st.ser == SER_CLOSE) && (st.bit_idx != 3'h0);
  endsequence

  // Strobe period, latch, fall and frame window
  AST_STROBE_PERIOD: assert property (next_st.strobe && !st.strobe && seen_rise
    |-> since_rise == TICK_CYCLES - 1) else $error("strobe period wrong");
  AST_LATCH_AT_RISE: assert property ($rose(st.strobe)
    |-> st.snap_g == $past(st.acc_g) && st.snap_a == $past(st.acc_a)
      && st.acc_g == ($past(gyro_valid) ? $past(gyro_delta) : '0))
    else $error("counts not latched with strobe");
  AST_STROBE_FALL: assert property ($fell(st.strobe)
    |-> st.ser == SER_IDLE && $past(st.ser) == SER_CLOSE)
    else $error("strobe fell outside frame end");
  AST_NO_EARLY_PACKET: assert property ($rose(st.strobe) |-> $past(st.pin[PIN_INIT]))
    else $error("packet before init");
  AST_HOLD_BEFORE_INIT: assert property (!st.pin[PIN_INIT] && !st.strobe
    |=> !st.strobe) else $error("strobe raised before init");
  AST_TX_WINDOW: assert property ($fell(st.strobe)
    |-> since_rise >= TX_DELAY_CYCLES && since_rise <= TX_LIMIT_CYCLES)
    else $error("frame outside window");

  // Link clock and data placement bit by bit
  AST_IDLE_LINE: assert property (st.ser == SER_IDLE |-> st.sclk && st.sdata)
    else $error("link not idle high");
  AST_DATA_ON_FALL: assert property ($changed(st.sdata)
    |-> $fell(st.sclk) || st.ser == SER_IDLE) else $error("data changed off falling edge");
  AST_OPEN_FLAG: assert property ((st.ser == SER_OPEN) ##0 fall_edge
    |=> st.sdata == FLAG_PATTERN[$past(st.bit_idx)])
    else $error("opening flag bit wrong");
  AST_BODY_LSB_FIRST: assert property (body_bit_due ##0 fall_edge
    |=> st.sdata == $past(st.shreg[st.bit_idx])) else $error("data bit out of order");
  AST_STUFF_ZERO: assert property (stuff_due ##0 fall_edge |=> !st.sdata)
    else $error("missing inserted zero");
  AST_CLOSE_FLAG: assert property (close_bit_due ##0 fall_edge
    |=> st.sdata == FLAG_PATTERN[$past(st.bit_idx)]) else $error("closing flag bit wrong");
  AST_COUNTER_STEP: assert property ($fell(st.strobe)
    |-> st.pkt_cnt == $past(st.pkt_cnt) + 8'h01) else $error("packet counter not stepped");

endmodule

// *** sim/imu_nav_receiver.sv ***
`timescale 1ns/10ps
module imu_nav_receiver (
  // Serial link from the unit
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  // Decoded bytes and frame tally
  output logic [7:0]      rx_byte,
  output int              rx_seq,
  output int              frame_len,
  output int              frames
);
  int         ones = 0;
  int         nbits = 0;
  int         cnt = 0;
  logic       in_frame = 1'b0;
  logic [7:0] sh = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Nothing decoded at start
  initial begin
    rx_byte = 8'h00;
    rx_seq = 0;
    frame_len = 0;
    frames = 0;
  end

  // Sample on the rising link clock, drop stuffed zeros, find flags
  always @(posedge serial_clk) begin
    if (serial_data !== 1'b1 && ones == 5) begin
      ones = 0;
    end else if (serial_data !== 1'b1 && ones == 6) begin
      ones = 0;
      if (in_frame && cnt > 0) begin
        frame_len = cnt;
        in_frame = 1'b0;
        frames++;
      end else begin
        in_frame = 1'b1;
        cnt = 0;
        nbits = 0;
      end
    end else begin
      ones = (serial_data === 1'b1) ? ones + 1 : 0;
      if (in_frame) begin
        sh = {serial_data, sh[7:1]};
        nbits++;
        if (nbits == 8) begin
          rx_byte = sh;
          cnt++;
          nbits = 0;
          rx_seq++;
        end
      end
    end
  end
endmodule

// *** sim/imu_sample_frame_transmitter_tb.sv ***
`timescale 1ns/10ps
module imu_sample_frame_transmitter_tb;
  import imu_frame_pkg::*;

  localparam int unsigned TICK  = 36000;
  localparam int unsigned DELAY = 200;

  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  health_t    health;
  logic       gyro_valid;
  triad_t     gyro_delta;
  logic       accel_valid;
  triad_t     accel_delta;
  logic       validity_strobe;
  logic       serial_clk;
  logic       serial_data;
  logic [7:0] rx_byte;
  int         rx_seq;
  int         frame_len;
  int         frames;
  int         fail_count = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         rise_cyc = 0;
  int         n_rise = 0;
  time        t_sclk = 0;
  logic       strobe_q = 1'b0;
  triad_t     sum_g = '0;
  triad_t     sum_a = '0;
  logic [7:0] exp_q[$];
  logic [7:0] pkt[16];
  logic       idle_strobe;
  logic       idle_sclk;
  logic       idle_sdata;
  logic       idle_noise = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and parts
  always #2.5 mclk = ~mclk;

  imu_sample_frame_transmitter #(
    .TICK_CYCLES     (TICK),
    .TX_DELAY_CYCLES (DELAY)
  ) u_dut (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .health          (health),
    .gyro_valid      (gyro_valid),
    .gyro_delta      (gyro_delta),
    .accel_valid     (accel_valid),
    .accel_delta     (accel_delta),
    .validity_strobe (validity_strobe),
    .serial_clk      (serial_clk),
    .serial_data     (serial_data)
  );

  imu_nav_receiver u_nav (
    .serial_clk  (serial_clk),
    .serial_data (serial_data),
    .rx_byte     (rx_byte),
    .rx_seq      (rx_seq),
    .frame_len   (frame_len),
    .frames      (frames)
  );

  // Second unit whose init never completes; it must stay silent
  imu_sample_frame_transmitter #(
    .TICK_CYCLES     (1000),
    .TX_DELAY_CYCLES (DELAY)
  ) u_dut_idle (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .health          (health_t'({health[4:1], 1'b0})),
    .gyro_valid      (gyro_valid),
    .gyro_delta      (gyro_delta),
    .accel_valid     (accel_valid),
    .accel_delta     (accel_delta),
    .validity_strobe (idle_strobe),
    .serial_clk      (idle_sclk),
    .serial_data     (idle_sdata)
  );

  // Any strobe or link activity before init is noted
  always @(negedge mclk) begin
    if (arst_n && {idle_strobe, idle_sclk, idle_sdata} !== 3'b011) idle_noise = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and close
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Note the 16 payload bytes and the inverted check bytes, low first
  task automatic push_packet(input logic [7:0] cnt8, input logic [7:0] st);
    logic [15:0] crc;
    pkt[0] = 8'h7e;
    pkt[1] = cnt8;
    pkt[2] = st;
    for (int i = 0; i < 3; i++) begin
      pkt[3 + 2 * i] = sum_g.cnt[i][15:8];
      pkt[4 + 2 * i] = sum_g.cnt[i][7:0];
      pkt[9 + 2 * i] = sum_a.cnt[i][15:8];
      pkt[10 + 2 * i] = sum_a.cnt[i][7:0];
    end
    pkt[15] = 8'h00;
    for (int i = 0; i < 15; i++) pkt[15] ^= pkt[i];
    crc = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      crc ^= {8'h00, pkt[i]};
      for (int b = 0; b < 8; b++) crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
      exp_q.push_back(pkt[i]);
    end
    exp_q.push_back(~crc[7:0]);
    exp_q.push_back(~crc[15:8]);
  endtask

  // Count edges since reset release
  always @(posedge mclk) begin
    if (arst_n) cyc <= cyc + 1;
  end

  // Falling-edge driver: latch expectations at the strobe rise, then new increments
  always @(negedge mclk) begin
    if (arst_n) begin
      if (validity_strobe === 1'b1 && !strobe_q) begin
        check("strobe rise cycle", cyc, (n_rise + 1) * TICK);
        rise_cyc = cyc;
        push_packet(n_rise[7:0], {~health.selftest_ok, ~health.gyro_en,
                    ~health.not_hot, ~health.not_cold, 4'h0});
        n_rise++;
        sum_g = '0;
        sum_a = '0;
        health = health_t'({4'($urandom), 1'b1});
      end
      for (int i = 0; i < 3; i++) begin
        if (gyro_valid) sum_g.cnt[i] += gyro_delta.cnt[i];
        if (accel_valid) sum_a.cnt[i] += accel_delta.cnt[i];
      end
      strobe_q = validity_strobe;
    end
    gyro_valid = arst_n & 1'($urandom);
    accel_valid = arst_n & 1'($urandom);
    gyro_delta = triad_t'({16'($urandom), 16'($urandom), 16'($urandom)});
    accel_delta = triad_t'({16'($urandom), 16'($urandom), 16'($urandom)});
  end

  // Link bit period and time of the last sampling edge
  always @(posedge serial_clk) begin
    if (t_sclk != 0 && $time - t_sclk < 2000) check("bit period ns", 32'($time - t_sclk), 1000);
    t_sclk = $time;
  end

  // Strobe fall: frame timing and frame size
  always @(negedge validity_strobe) begin
    if (arst_n === 1'b1) begin
      check("frame end window", 32'(cyc - rise_cyc >= DELAY && cyc - rise_cyc <= TICK), 1);
      check("fall after last bit", 32'($time - t_sclk >= 495 && $time - t_sclk <= 505), 1);
      check("frame byte count", frame_len, 18);
    end
  end

  // Each decoded byte against the oldest note
  always @(rx_seq) begin
    #1;
    if (exp_q.size() == 0) begin
      check("spare byte", 1, 0);
    end else begin
      check("frame byte", {24'h0, rx_byte}, {24'h0, exp_q.pop_front()});
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h5023e65c));
    health = health_t'({4'($urandom), 1'b1});
    gyro_valid = 1'b0;
    accel_valid = 1'b0;
    gyro_delta = '0;
    accel_delta = '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 115000 && frames < 2; i++) @(posedge mclk);
    if (frames < 2) begin
      fail_count++;
    end else begin
      repeat (300) @(posedge mclk);
      check("packets per strobe", frames, n_rise);
      check("bytes left", exp_q.size(), 0);
    end
    check("output before init", idle_noise, 1'b0);
    conclude();
  end
endmodule
